//--- hw/timer_pkg.sv
package timer_pkg;

  // Register port addresses
  localparam logic [1:0] ADDR_COUNT_VALUE  = 2'h0;
  localparam logic [1:0] ADDR_INTR_CONTROL = 2'h1;
  localparam logic [1:0] ADDR_OPTION       = 2'h2;

  // Reset values
  localparam logic [7:0] COUNT_VALUE_RST  = 8'h00;
  localparam logic [7:0] INTR_CONTROL_RST = 8'h00;
  localparam logic [7:0] OPTION_RST       = 8'hFF;

  // interrupt_control fields
  localparam int OVF_IRQ_EN_BIT = 5;
  localparam int OVF_FLAG_BIT   = 2;

  // option_settings fields
  localparam int CLK_SRC_SEL_BIT = 5;
  localparam int EDGE_SEL_BIT    = 4;
  localparam int PRESC_ASGN_BIT  = 3;
  localparam int RATE_LSB        = 0;
  localparam int RATE_W          = 3;

  // Instruction cycle: four oscillator periods, phases one to four
  localparam int             CLK_PERIOD_NS  = 10;
  localparam int             CLKS_PER_INSTR = 4;
  localparam logic [1:0]     PHASE_TWO      = 2'h1;
  localparam logic [1:0]     PHASE_FOUR     = 2'h3;
  localparam logic [1:0]     PHASE_LAST     = 2'h3;

  // Increment hold-off after a write to the count value
  localparam int         INHIBIT_INSTR = 2;
  localparam logic [3:0] INHIBIT_CLKS  = 4'(INHIBIT_INSTR * CLKS_PER_INSTR);

  localparam logic [7:0] COUNT_MAX = 8'hFF;

endpackage

//--- hw/pin_edge_sync.sv
`timescale 1ns/10ps
module pin_edge_sync
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin side
  input  wire logic pin_in,
  // Core side
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Edges are seen only past the second stage
  assign level = st_reg.s2;
  assign rise  = st_reg.s2 & ~st_reg.s3;
  assign fall  = ~st_reg.s2 & st_reg.s3;

endmodule

//--- hw/shared_prescaler.sv
`timescale 1ns/10ps
module shared_prescaler
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic [3:0] div_exp,
  // Output
  output logic            tick,
  output logic            level,
  output logic [7:0]      count
);

  typedef struct packed {
    logic [7:0] cnt;
  } presc_state_t;

  presc_state_t st_reg;
  presc_state_t st_next;
  logic [7:0]   mask;

  // Divide by two to the power div_exp; exponent 8 gives a full mask
  assign mask  = ~(8'hFF << div_exp);
  assign tick  = step & ((st_reg.cnt & mask) == mask);
  assign level = (div_exp == 4'h0) ? 1'b0 : st_reg.cnt[3'(div_exp - 4'h1)];
  assign count = st_reg.cnt;

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.cnt = 8'h00;
    end else if (step) begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

//--- hw/count_timer.sv
// Functional notes
// - Eight-bit count value works as cycle timer or external edge counter.
// - Timer mode counts each instruction cycle, or each prescaler output when assigned.
// - A write to the count value blocks counting for two instruction cycles.
// - Counter mode counts external pin edges of the chosen polarity.
// - One prescaler serves counter or watchdog; assign bit zero gives it to counter.
// - Prescaler on counter: rate field picks eight ratios from 1:2 to 1:256.
// - Undivided counting only when the prescaler belongs to the watchdog.
// - Prescaler count is neither readable nor writable by software.
// - Count value write clears the prescaler while assigned to the counter.
// - Clear-watchdog clears watchdog and prescaler while assigned to the watchdog.
// - Wrap from FF to 00 sets the overflow flag regardless of enable.
// - Hardware never clears the overflow flag; software clears it by writing.
// - Overflow interrupt request only while the enable bit is set.
// - During sleep the count holds and does not advance.
// - Edge select one counts falling edges, zero counts rising edges.
// - External count is sampled on phase two and phase four.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module count_timer
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // Register port
  input  wire logic [1:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Core status and pins
  input  wire logic       SLEEP,
  input  wire logic       CLEAR_WATCHDOG_INSTR,
  input  wire logic       EXTERNAL_COUNT_INPUT,
  // Outputs
  output logic            IRQ,
  output logic            WATCHDOG_TICK,
  output logic            WATCHDOG_CLEAR
);

  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] count_value;
    logic [7:0] interrupt_control;
    logic [7:0] option_settings;
    logic [3:0] inhibit;
    logic       sample;
    logic [7:0] rdata;
    logic       irq;
    logic       wdt_tick;
    logic       wdt_clear;
  } timer_state_t;

  timer_state_t st_reg;
  timer_state_t st_next;

  logic       clock_source_select;
  logic       edge_select;
  logic       prescaler_assign;
  logic [2:0] rate_field;
  logic       wr_count;
  logic       wr_intr;
  logic       wr_opt;
  logic       cycle_tick;
  logic       sample_point;
  logic       pin_level;
  logic       pin_rise;
  logic       pin_fall;
  logic       ext_edge;
  logic       presc_clear;
  logic       presc_step;
  logic [3:0] presc_exp;
  logic       presc_tick;
  logic       presc_level;
  logic [7:0] presc_count;
  logic       timer_pulse;
  logic       counter_level;
  logic       counter_pulse;
  logic       incr;

  assign clock_source_select = st_reg.option_settings[CLK_SRC_SEL_BIT];
  assign edge_select         = st_reg.option_settings[EDGE_SEL_BIT];
  assign prescaler_assign    = st_reg.option_settings[PRESC_ASGN_BIT];
  assign rate_field          = st_reg.option_settings[RATE_LSB +: RATE_W];

  assign wr_count = WR && (ADDR == ADDR_COUNT_VALUE);
  assign wr_intr  = WR && (ADDR == ADDR_INTR_CONTROL);
  assign wr_opt   = WR && (ADDR == ADDR_OPTION);

  assign cycle_tick   = (st_reg.phase == PHASE_LAST);
  assign sample_point = (st_reg.phase == PHASE_TWO) || (st_reg.phase == PHASE_FOUR);

  pin_edge_sync u_pin (
    .clk    (CLK),
    .rst_n  (RSTN),
    .pin_in (EXTERNAL_COUNT_INPUT),
    .level  (pin_level),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  assign ext_edge = edge_select ? pin_fall : pin_rise;

  assign presc_clear = (wr_count && !prescaler_assign) || (CLEAR_WATCHDOG_INSTR && prescaler_assign);

  // one prescaler, routed by the assign bit; frozen in sleep only while on the counter
  assign presc_step = prescaler_assign ? cycle_tick
                    : (!SLEEP && (clock_source_select ? ext_edge : cycle_tick));

  // ratio exponent, one step higher for the counter
  assign presc_exp = prescaler_assign ? {1'b0, rate_field} : ({1'b0, rate_field} + 4'h1);

  shared_prescaler u_presc (
    .clk     (CLK),
    .rst_n   (RSTN),
    .clear   (presc_clear),
    .step    (presc_step),
    .div_exp (presc_exp),
    .tick    (presc_tick),
    .level   (presc_level),
    .count   (presc_count)
  );

  // timer source, undivided only without the prescaler
  assign timer_pulse = prescaler_assign ? cycle_tick : presc_tick;

  // counter source; inverting makes the chosen edge a rise
  assign counter_level = prescaler_assign ? (pin_level ^ edge_select) : presc_level;

  // rise seen between two phase samples
  assign counter_pulse = sample_point && counter_level && !st_reg.sample;

  assign incr = !SLEEP && (st_reg.inhibit == 4'h0) && !wr_count
             && (clock_source_select ? counter_pulse : timer_pulse);

  always_comb begin
    st_next           = st_reg;
    st_next.phase     = st_reg.phase + 2'h1;
    st_next.rdata     = 8'h00;
    st_next.wdt_clear = CLEAR_WATCHDOG_INSTR && prescaler_assign;
    st_next.wdt_tick  = prescaler_assign && presc_tick;
    if (sample_point) begin
      st_next.sample = counter_level;
    end
    if (st_reg.inhibit != 4'h0) begin
      st_next.inhibit = st_reg.inhibit - 4'h1;
    end
    if (wr_count) begin
      st_next.count_value = WDATA;
      st_next.inhibit     = INHIBIT_CLKS;
    end else if (incr) begin
      st_next.count_value = st_reg.count_value + 8'h01;
    end
    if (wr_intr) begin
      st_next.interrupt_control = WDATA;
    end
    // overflow sets; set beats a clearing write
    if (incr && (st_reg.count_value == COUNT_MAX)) begin
      st_next.interrupt_control[OVF_FLAG_BIT] = 1'b1;
    end
    if (wr_opt) begin
      st_next.option_settings = WDATA;
    end
    // prescaler count has no read path
    if (RD) begin
      unique case (ADDR)
        ADDR_COUNT_VALUE:  st_next.rdata = st_reg.count_value;
        ADDR_INTR_CONTROL: st_next.rdata = st_reg.interrupt_control;
        ADDR_OPTION:       st_next.rdata = st_reg.option_settings;
        default:           st_next.rdata = 8'h00;
      endcase
    end
    st_next.irq = st_next.interrupt_control[OVF_FLAG_BIT] && st_next.interrupt_control[OVF_IRQ_EN_BIT];
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg                   <= '0;
      st_reg.count_value       <= COUNT_VALUE_RST;
      st_reg.interrupt_control <= INTR_CONTROL_RST;
      st_reg.option_settings   <= OPTION_RST;
      // Starts high so a pin already at the counting level is not taken as an edge
      st_reg.sample            <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA          = st_reg.rdata;
  assign IRQ            = st_reg.irq;
  assign WATCHDOG_TICK  = st_reg.wdt_tick;
  assign WATCHDOG_CLEAR = st_reg.wdt_clear;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  property p_write_inhibit;
    wr_count |=> !incr [*8];
  endproperty
  a_write_inhibit: assert property (p_write_inhibit) else $error("count advanced during write hold-off");

  property p_overflow_sets;
    (incr && st_reg.count_value == COUNT_MAX) |=> st_reg.interrupt_control[OVF_FLAG_BIT]
      && st_reg.count_value == 8'h00;
  endproperty
  a_overflow_sets: assert property (p_overflow_sets) else $error("wrap did not set overflow flag");

  property p_flag_sticky;
    (st_reg.interrupt_control[OVF_FLAG_BIT] && !wr_intr) |=> st_reg.interrupt_control[OVF_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag cleared by hardware");

  property p_irq_gated;
    !st_reg.interrupt_control[OVF_IRQ_EN_BIT] && !wr_intr |=> !IRQ;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("interrupt raised while disabled");

  property p_sleep_hold;
    (SLEEP && !wr_count) |=> $stable(st_reg.count_value);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved during sleep");

  property p_write_clears_presc;
    (wr_count && !prescaler_assign) |=> presc_count == 8'h00;
  endproperty
  a_write_clears_presc: assert property (p_write_clears_presc) else $error("prescaler not cleared by write");

  property p_wdt_clear;
    (CLEAR_WATCHDOG_INSTR && prescaler_assign) |=> presc_count == 8'h00 && WATCHDOG_CLEAR;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear missed prescaler");

  property p_timer_direct;
    (cycle_tick && !clock_source_select && prescaler_assign && !SLEEP && !WR && st_reg.inhibit == 4'h0)
      |=> st_reg.count_value == $past(st_reg.count_value) + 8'h01;
  endproperty
  a_timer_direct: assert property (p_timer_direct) else $error("timer missed an instruction cycle");

  property p_counter_phase;
    (incr && clock_source_select) |-> sample_point;
  endproperty
  a_counter_phase: assert property (p_counter_phase) else $error("external count outside sample phase");

  property p_timer_presc_rate0;
    (incr && !clock_source_select && !prescaler_assign && rate_field == 3'h0) |=> !incr [*7];
  endproperty
  a_timer_presc_rate0: assert property (p_timer_presc_rate0) else $error("divide by two ran too fast");

  property p_write_loads;
    wr_count |=> st_reg.count_value == $past(WDATA);
  endproperty
  a_write_loads: assert property (p_write_loads) else $error("count write not loaded");

  property p_count_steps;
    !wr_count |=> (st_reg.count_value == $past(st_reg.count_value))
      || (st_reg.count_value == $past(st_reg.count_value) + 8'h01);
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("count jumped by more than one");

  property p_wdt_tick_owner;
    !prescaler_assign |=> !WATCHDOG_TICK;
  endproperty
  a_wdt_tick_owner: assert property (p_wdt_tick_owner) else $error("watchdog ticked without prescaler");

  property p_cw_ignored;
    (CLEAR_WATCHDOG_INSTR && !prescaler_assign) |=> !WATCHDOG_CLEAR;
  endproperty
  a_cw_ignored: assert property (p_cw_ignored) else $error("watchdog clear passed on counter side");

  property p_sleep_presc;
    (SLEEP && !prescaler_assign && !presc_clear) |=> $stable(presc_count);
  endproperty
  a_sleep_presc: assert property (p_sleep_presc) else $error("counter prescaler moved during sleep");

  property p_counter_edge_pol;
    (incr && clock_source_select && prescaler_assign) |-> (pin_level != edge_select);
  endproperty
  a_counter_edge_pol: assert property (p_counter_edge_pol) else $error("count on the wrong pin edge");

  property p_irq_follows;
    (st_reg.interrupt_control[OVF_FLAG_BIT] && st_reg.interrupt_control[OVF_IRQ_EN_BIT] && !wr_intr) |=> IRQ;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("enabled overflow gave no request");

  property p_unmapped_read;
    (RD && ADDR == 2'h3) |=> RDATA == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read returned data");

  c_overflow: cover property (incr && st_reg.count_value == COUNT_MAX);
  c_counter:  cover property (incr && clock_source_select);
  c_wdt:      cover property (CLEAR_WATCHDOG_INSTR && prescaler_assign);
  c_irq:      cover property ($rose(IRQ));
  c_wdt_tick: cover property (WATCHDOG_TICK);

endmodule

//--- sim/ext_pulse_src.sv
`timescale 1ns/10ps
module ext_pulse_src (
  // Clock
  input  wire logic clk,
  // Count pin
  output logic      pin
);
  initial pin = 1'b0;

  // Each level holds several clocks so the pin synchroniser can see it
  task automatic toggle(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge clk);
      pin <= ~pin;
    end
    repeat (hold) @(posedge clk);
  endtask
endmodule

//--- sim/tb_count_timer.sv
`timescale 1ns/10ps
module tb_count_timer;
  import timer_pkg::*;
  logic       CLK, RSTN, WR, RD, SLEEP, CLEAR_WATCHDOG_INSTR;
  logic [1:0] ADDR;
  logic [7:0] WDATA, RDATA, a, b;
  logic       IRQ, WATCHDOG_TICK, WATCHDOG_CLEAR;
  wire        EXTERNAL_COUNT_INPUT;
  int         n_mismatch, tests_run, n_tick, n0;

  count_timer u_count_timer (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SLEEP(SLEEP), .CLEAR_WATCHDOG_INSTR(CLEAR_WATCHDOG_INSTR),
    .EXTERNAL_COUNT_INPUT(EXTERNAL_COUNT_INPUT), .IRQ(IRQ), .WATCHDOG_TICK(WATCHDOG_TICK),
    .WATCHDOG_CLEAR(WATCHDOG_CLEAR));
  ext_pulse_src u_ext_pulse_src (.clk(CLK), .pin(EXTERNAL_COUNT_INPUT));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) if (WATCHDOG_TICK === 1'b1) n_tick <= n_tick + 1;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= ad; WDATA <= d; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] ad, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= ad; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic delta(input int p, input logic [7:0] e, input string nm);
    rd(ADDR_COUNT_VALUE, a);
    repeat (p - 2) @(posedge CLK);
    rd(ADDR_COUNT_VALUE, b);
    chk(nm, e, b - a);
  endtask
  task automatic cwd(input logic e);
    @(posedge CLK);
    CLEAR_WATCHDOG_INSTR <= 1'b1;
    @(posedge CLK);
    CLEAR_WATCHDOG_INSTR <= 1'b0;
    #1 chk("watchdog clear", {7'h00, e}, {7'h00, WATCHDOG_CLEAR});
  endtask
  task automatic to_wdt(input logic [7:0] opt);
    cwd(1'b0);
    wr(ADDR_COUNT_VALUE, 8'h00);
    wr(ADDR_OPTION, opt);
    cwd(1'b1);
  endtask

  task automatic t_reset;
    rd(ADDR_COUNT_VALUE, a); chk("count reset", COUNT_VALUE_RST, a);
    rd(ADDR_INTR_CONTROL, a); chk("intr reset", INTR_CONTROL_RST, a);
    rd(ADDR_OPTION, a); chk("option reset", OPTION_RST, a);
    wr(2'h3, 8'h5A);
    rd(2'h3, a); chk("unmapped", 8'h00, a);
  endtask
  task automatic t_timer_ovf;
    wr(ADDR_OPTION, 8'h08);
    delta(40, 8'h0A, "undivided rate");
    wr(ADDR_COUNT_VALUE, 8'hFE);
    rd(ADDR_COUNT_VALUE, a); chk("hold-off", 8'hFE, a);
    repeat (30) @(posedge CLK);
    rd(ADDR_INTR_CONTROL, a); chk("flag set", 8'h04, a);
    chk("irq masked", 8'h00, {7'h00, IRQ});
    repeat (100) @(posedge CLK);
    rd(ADDR_INTR_CONTROL, a); chk("flag kept", 8'h04, a);
    wr(ADDR_INTR_CONTROL, 8'h24);
    @(posedge CLK);
    #1 chk("irq on", 8'h01, {7'h00, IRQ});
    wr(ADDR_INTR_CONTROL, 8'h20);
    @(posedge CLK);
    #1 chk("irq off", 8'h00, {7'h00, IRQ});
    rd(ADDR_INTR_CONTROL, a); chk("flag cleared", 8'h20, a);
  endtask
  task automatic t_presc;
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_OPTION, 8'(r));
      delta(16 << r, 8'h02, "divided rate");
    end
    wr(ADDR_COUNT_VALUE, 8'h10);
    repeat (900) @(posedge CLK);
    rd(ADDR_COUNT_VALUE, a); chk("prescaler cleared", 8'h10, a);
  endtask
  task automatic t_sleep;
    wr(ADDR_OPTION, 8'h00);
    SLEEP <= 1'b1;
    delta(40, 8'h00, "sleep hold");
    @(posedge CLK);
    SLEEP <= 1'b0;
  endtask
  task automatic t_counter(input logic [7:0] opt, input int n, input logic [7:0] e);
    wr(ADDR_OPTION, opt);
    wr(ADDR_COUNT_VALUE, 8'h00);
    repeat (12) @(posedge CLK);
    u_ext_pulse_src.toggle(n, 8);
    repeat (10) @(posedge CLK);
    rd(ADDR_COUNT_VALUE, a); chk("edge count", e, a);
  endtask
  task automatic t_wdt(input logic [7:0] opt, input logic [7:0] e);
    wr(ADDR_OPTION, opt);
    n0 = n_tick;
    repeat (160) @(posedge CLK);
    chk("watchdog ticks", e, 8'(n_tick - n0));
    cwd(opt[PRESC_ASGN_BIT]);
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    RSTN = 1'b0; WR = 1'b0; RD = 1'b0; SLEEP = 1'b0; CLEAR_WATCHDOG_INSTR = 1'b0;
    ADDR = 2'h0; WDATA = 8'h00;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    t_reset();
    t_timer_ovf();
    cwd(1'b1);
    t_presc();
    t_sleep();
    to_wdt(8'h08);
    t_counter(8'h28, 3, 8'h02);
    t_counter(8'h38, 3, 8'h02);
    cwd(1'b1);
    t_counter(8'h20, 8, 8'h02);
    to_wdt(8'h28);
    t_wdt(8'h0A, 8'h0A);
    t_wdt(8'h02, 8'h00);
    end_sim();
  end
endmodule
